// ==== dv/cwdc_card_model.sv ====
// Card in the socket: sense, detect and removal lines
module cwdc_card_model (
  input  wire logic aclk,
  input  wire logic card_in,
  input  wire logic vs1_level,
  input  wire logic vs2_level,
  output logic      sense1_pin,
  output logic      sense2_pin,
  output logic      card_detect1_pin,
  output logic      card_detect2_pin,
  output logic      card_removed
);
  timeunit 1ns;
  timeprecision 1ns;
  logic was_in = 1'b1;
  // Empty socket: pull-ups win on every line
  assign card_detect1_pin = !card_in;
  assign card_detect2_pin = !card_in;
  assign sense1_pin = card_in ? vs1_level : 1'b1;
  assign sense2_pin = card_in ? vs2_level : 1'b1;
  always_ff @(posedge aclk) begin
    was_in <= card_in;
  end
  // One cycle per pull-out
  assign card_removed = was_in && !card_in;
endmodule // cwdc_card_model

// ==== dv/cwdc_monitor.sv ====
// Concurrent checks on the window/detect register block
module cwdc_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic [5:0]  offset_upper_bits [5],
  input wire logic [4:0]  window_attribute,
  input wire logic [4:0]  window_write_enable,
  input wire logic        ring_indicate_output,
  input wire logic        detect_change_irq,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rd_addr;
  // Read data is judged against the address taken earlier
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_addr <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr[9:2];
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_state_a: assert property (!$past(aresetn) |->
    window_write_enable == 5'h1F && window_attribute == 5'h00 && ring_indicate_output) else $error("reset state");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("late write answer");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
  error_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read data");
  word_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits");
  ctrl_reserved_a: assert property (s_axi_rvalid && rd_addr == 8'h16 |-> (s_axi_rdata & 32'h2D) == 32'h0)
    else $error("control zero bits");
  window_mirror_a: assert property (s_axi_rvalid && rd_addr == 8'h15 |->
    s_axi_rdata[5:0] == offset_upper_bits[0] && s_axi_rdata[6] == window_attribute[0]
    && s_axi_rdata[7] != window_write_enable[0]) else $error("window outputs");
  ring_hold_a: assert property (!ring_indicate_output && detect_change_irq ##1 detect_change_irq
    |-> !ring_indicate_output) else $error("ring rose early");
  cover property ($fell(ring_indicate_output));
  cover property ($rose(detect_change_irq));
  cover property ($rose(irq));
endmodule // cwdc_monitor
bind cwdc_regs cwdc_monitor mon (.*);

// ==== dv/testbench.sv ====
// Self-checking bench for the window/detect register block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn, clk_en, global_reset_n, bus_reset_n, card_in, vs1_level, vs2_level;
  logic sense1_pin, sense2_pin, card_detect1_pin, card_detect2_pin, card_removed;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [5:0] offset_upper_bits [5];
  logic [4:0] window_attribute, window_write_enable;
  logic ring_indicate_output, detect_change_irq, irq;
  int num_errors = 0;
  int checks = 0;
  cwdc_regs uut (.*);
  cwdc_card_model card (.*);
  always #5 aclk = ~aclk;
  task automatic chk(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Sampled at the falling edge, acted on at the next rising edge
  task automatic bus(input logic wr, input logic [7:0] a, d);
    logic ta, tw, done;
    done = 1'b0;
    s_axi_awaddr <= {2'b00, a, 2'b00};
    s_axi_araddr <= {2'b00, a, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    while (!done) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
      tw = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready;
      rdat = s_axi_rdata;
      resp = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
      if (tw) s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic rdc(input logic [7:0] a, e);
    bus(1'b0, a, 8'h00);
    chk(rdat, {24'h0, e});
  endtask
  task automatic t_windows;
    logic [7:0] v [5] = '{8'hFF, 8'h80, 8'h40, 8'h3F, 8'h15};
    logic [7:0] a [5] = '{8'h15, 8'h1D, 8'h25, 8'h2D, 8'h35};
    for (int i = 0; i < 5; i++) begin
      rdc(a[i], 8'h00);
      bus(1'b1, a[i], v[i]);
      rdc(a[i], v[i]);
      chk(offset_upper_bits[i], v[i][5:0]);
      chk(window_attribute[i], v[i][6]);
      chk(window_write_enable[i], !v[i][7]);
    end
    rdc(8'h17, 8'h00);
    chk(resp, 2'h2);
    bus(1'b1, 8'h17, 8'hFF);
    chk(resp, 2'h2);
    $display("windows done");
  endtask
  task automatic t_ctrl;
    vs1_level <= 1'b0;
    repeat (6) @(posedge aclk);
    bus(1'b1, 8'h16, 8'hFF);
    rdc(8'h16, 8'h92);
    vs1_level <= 1'b1;
    vs2_level <= 1'b0;
    repeat (6) @(posedge aclk);
    rdc(8'h16, 8'h52);
    bus(1'b1, 8'h16, 8'h00);
    vs2_level <= 1'b1;
    $display("control done");
  endtask
  task automatic t_swdet;
    bus(1'b1, 8'h44, 8'h01);
    bus(1'b1, 8'h48, 8'h00);
    bus(1'b1, 8'h16, 8'h20);
    rdc(8'h4C, 8'h00);
    chk(irq, 1'b0);
    bus(1'b1, 8'h48, 8'h03);
    bus(1'b1, 8'h16, 8'h20);
    rdc(8'h16, 8'hC0);
    rdc(8'h4C, 8'h08);
    chk(detect_change_irq, 1'b1);
    chk(irq, 1'b1);
    bus(1'b1, 8'h44, 8'h00);
    chk(irq, 1'b0);
    bus(1'b1, 8'h44, 8'h01);
    bus(1'b1, 8'h4C, 8'h08);
    rdc(8'h4C, 8'h00);
    chk(detect_change_irq, 1'b0);
    bus(1'b1, 8'h40, 8'h03);
    chk(irq, 1'b0);
    bus(1'b1, 8'h48, 8'h01);
    bus(1'b1, 8'h16, 8'h20);
    rdc(8'h4C, 8'h08);
    rdc(8'h4C, 8'h00);
    bus(1'b1, 8'h40, 8'h03);
    $display("software detect done");
  endtask
  task automatic t_wake;
    bus(1'b1, 8'h48, 8'h03);
    bus(1'b1, 8'h16, 8'h10);
    card_in <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(ring_indicate_output, 1'b0);
    rdc(8'h15, 8'hFF);
    chk(ring_indicate_output, 1'b0);
    bus(1'b1, 8'h4C, 8'h08);
    rdc(8'h4C, 8'h00);
    chk(ring_indicate_output, 1'b1);
    bus(1'b1, 8'h16, 8'h00);
    card_in <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(ring_indicate_output, 1'b1);
    bus(1'b1, 8'h4C, 8'h08);
    $display("wake done");
  endtask
  task automatic t_removal;
    bus(1'b1, 8'h16, 8'h12);
    card_in <= 1'b0;
    repeat (8) @(posedge aclk);
    rdc(8'h15, 8'h00);
    rdc(8'h16, 8'hC0);
    card_in <= 1'b1;
    repeat (8) @(posedge aclk);
    bus(1'b1, 8'h4C, 8'h08);
    $display("removal done");
  endtask
  task automatic t_resets;
    bus(1'b1, 8'h48, 8'h00);
    bus(1'b1, 8'h15, 8'h2A);
    bus_reset_n <= 1'b0;
    @(posedge aclk);
    bus_reset_n <= 1'b1;
    rdc(8'h15, 8'h00);
    bus(1'b1, 8'h48, 8'h04);
    bus(1'b1, 8'h15, 8'h2A);
    bus_reset_n <= 1'b0;
    @(posedge aclk);
    bus_reset_n <= 1'b1;
    rdc(8'h15, 8'h2A);
    global_reset_n <= 1'b0;
    @(posedge aclk);
    global_reset_n <= 1'b1;
    rdc(8'h15, 8'h00);
    rdc(8'h48, 8'h00);
    $display("resets done");
  endtask
  task automatic t_freeze;
    bus(1'b1, 8'h40, 8'h03);
    clk_en <= 1'b0;
    card_in <= 1'b0;
    repeat (8) @(posedge aclk);
    card_in <= 1'b1;
    repeat (8) @(posedge aclk);
    clk_en <= 1'b1;
    repeat (8) @(posedge aclk);
    rdc(8'h40, 8'h00);
    aresetn <= 1'b0;
    card_in <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (12) @(posedge aclk);
    rdc(8'h40, 8'h00);
    chk(ring_indicate_output, 1'b1);
    card_in <= 1'b1;
    repeat (8) @(posedge aclk);
    rdc(8'h40, 8'h01);
    $display("freeze and reset done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 6'h00;
    {clk_en, global_reset_n, bus_reset_n, card_in, vs1_level, vs2_level} = 6'h3F;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'h1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_windows;
    t_ctrl;
    t_swdet;
    t_wake;
    t_removal;
    t_resets;
    t_freeze;
    end_of_test;
  end
  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    end_of_test;
  end
endmodule // testbench

// ==== rtl/cwdc_regs.sv ====
// Memory window offset high bytes and card-detect control over AXI4-Lite
// Operation
// - Bits 5..0 hold window offset A25..A20
// - Bit 6 picks common or attribute memory
// - Bit 7 gates writes through the window
// - Windows at 15h,1Dh,25h,2Dh,35h, reset zero
// - Bits 7,6 show live sense pin levels
// - Software detect write raises detect change
// - Detect disabled: software write does nothing
// - Software detect bit reads zero, self clears
// - Write-one clear of change also clears it
// - Wake enable plus hardware detect change lowers ring
// - Ring low until change flag or wake enable cleared
// - Removal resets registers when clear bit set
// - Bits 3,2,0 read zero, ignore writes
// - PME on: global reset only, else either
// - Clear mode: read clears or write-one clears
`include "cwdc_params.svh"
module cwdc_regs
  import cwdc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic        global_reset_n,
  input  wire logic        bus_reset_n,
  input  wire logic        sense1_pin,
  input  wire logic        sense2_pin,
  input  wire logic        card_detect1_pin,
  input  wire logic        card_detect2_pin,
  input  wire logic        card_removed,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [5:0]       offset_upper_bits [`CWDC_NUM_WIN],
  output logic [4:0]       window_attribute,
  output logic [4:0]       window_write_enable,
  output logic             ring_indicate_output,
  output logic             detect_change_irq,
  output logic             irq
);

  function automatic logic [2:0] win_index(input logic [7:0] off);
    case (off)
      `CWDC_OFF_WIN0_HIGH: win_index = 3'h0;
      `CWDC_OFF_WIN1_HIGH: win_index = 3'h1;
      `CWDC_OFF_WIN2_HIGH: win_index = 3'h2;
      `CWDC_OFF_WIN3_HIGH: win_index = 3'h3;
      `CWDC_OFF_WIN4_HIGH: win_index = 3'h4;
      default:             win_index = 3'h7;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [7:0] off);
    is_mapped = (win_index(off) != 3'h7) || off == `CWDC_OFF_DETECT_CTRL || off == `CWDC_OFF_STATUS
                || off == `CWDC_OFF_MASK || off == `CWDC_OFF_CONFIG || off == `CWDC_OFF_CHANGE;
  endfunction

  // Byte address is four times the register index
  function automatic logic [7:0] reg_index(input logic [11:0] addr);
    reg_index = addr[9:2];
  endfunction

  // Pin synchronisers: change counts once stages two and three agree
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [3:0] pin_level;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
      pin_level <= 4'h0;
    end else if (clk_en) begin
      sync1 <= {card_detect2_pin, card_detect1_pin, sense2_pin, sense1_pin};
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < 4; i++) begin
        if (sync2[i] == sync3[i]) begin
          pin_level[i] <= sync3[i];
        end
      end
    end
  end

  logic hw_detect_change;
  logic detect_primed;
  // Pipeline needs five edges to carry the first settled level
  logic [2:0] settle_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt <= 3'h0;
    end else if (clk_en && settle_cnt != `CWDC_SETTLE_CYCLES) begin
      settle_cnt <= settle_cnt + 3'h1;
    end
  end
  assign detect_primed = (settle_cnt == `CWDC_SETTLE_CYCLES);
  logic [1:0] detect_prev;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detect_prev <= 2'h0;
    end else if (clk_en) begin
      detect_prev <= pin_level[3:2];
    end
  end
  // Levels settling after reset, empty socket too, are no change
  assign hw_detect_change = detect_primed && (detect_prev != pin_level[3:2]);

  // Write channel: address and data taken in either order
  cwdc_wstate_t wstate;
  logic         aw_held;
  logic         w_held;
  logic [7:0]   aw_off;
  logic [31:0]  w_data;
  logic         w_lane0;
  logic         wr_fire;

  // Readies drop with clock enable so no beat is lost while frozen
  assign s_axi_awready = clk_en && (wstate == CWDC_W_IDLE) && !aw_held;
  assign s_axi_wready  = clk_en && (wstate == CWDC_W_IDLE) && !w_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_off  <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_lane0 <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_off  <= reg_index(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        w_data  <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  assign wr_fire = (wstate == CWDC_W_IDLE) && aw_held && w_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate       <= CWDC_W_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (clk_en) begin
      case (wstate)
        CWDC_W_IDLE: begin
          if (wr_fire) begin
            wstate       <= CWDC_W_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(aw_off) ? 2'h0 : 2'h2;
          end
        end
        CWDC_W_RESP: begin
          if (s_axi_bready) begin
            wstate       <= CWDC_W_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wstate       <= CWDC_W_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Only lane 0 carries a register; other lanes are dropped
  logic       wr_byte;
  logic [7:0] wb;
  assign wr_byte = wr_fire && w_lane0;
  assign wb      = w_data[7:0];

  logic rd_fire;
  assign s_axi_arready = clk_en && !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  // Own configuration: detect interrupt enable, clear method, PME enable
  logic detect_enable;
  logic flag_clear_method;
  logic pme_enable;
  always_ff @(posedge aclk) begin
    if (!aresetn || !global_reset_n) begin
      detect_enable     <= 1'b0;
      flag_clear_method <= 1'b0;
      pme_enable        <= 1'b0;
    end else if (clk_en && wr_byte && aw_off == `CWDC_OFF_CONFIG) begin
      detect_enable     <= wb[`CWDC_CFG_DETECT_EN];
      flag_clear_method <= wb[`CWDC_CFG_CLEAR_MODE];
      pme_enable        <= wb[`CWDC_CFG_PME_EN];
    end
  end

  // Compatibility register reset: global always, bus only without PME
  logic regs_clear;
  assign regs_clear = !global_reset_n || (!bus_reset_n && !pme_enable);

  logic removal_clear;
  logic removal_register_clear;
  logic detect_wake_enable;
  // Removal clear wins over a write in the same cycle
  assign removal_clear = removal_register_clear && card_removed;

  // Window offset high bytes
  cwdc_byte_t win_reg [`CWDC_NUM_WIN];
  for (genvar g = 0; g < `CWDC_NUM_WIN; g++) begin : g_win
    always_ff @(posedge aclk) begin
      if (!aresetn || regs_clear) begin
        win_reg[g] <= `CWDC_WIN_RESET;
      end else if (clk_en) begin
        if (removal_clear) begin
          win_reg[g] <= `CWDC_WIN_RESET;
        end else if (wr_byte && win_index(aw_off) == 3'(g)) begin
          win_reg[g] <= wb;
        end
      end
    end
    assign offset_upper_bits[g]   = win_reg[g][5:0];
    assign window_attribute[g]    = win_reg[g][`CWDC_BIT_ATTR];
    assign window_write_enable[g] = !win_reg[g][`CWDC_BIT_WP];
  end

  // Card-detect control writable bits
  always_ff @(posedge aclk) begin
    if (!aresetn || regs_clear) begin
      detect_wake_enable     <= 1'b0;
      removal_register_clear <= 1'b0;
    end else if (clk_en) begin
      if (removal_clear) begin
        detect_wake_enable     <= 1'b0;
        removal_register_clear <= 1'b0;
      end else if (wr_byte && aw_off == `CWDC_OFF_DETECT_CTRL) begin
        detect_wake_enable     <= wb[`CWDC_BIT_WAKE];
        removal_register_clear <= wb[`CWDC_BIT_REMCLR];
      end
    end
  end

  // Software detect pulse; never stored so it reads zero
  logic sw_detect;
  assign sw_detect = clk_en && wr_byte && aw_off == `CWDC_OFF_DETECT_CTRL
                     && wb[`CWDC_BIT_SWDETECT] && detect_enable;

  // Card-detect change flag; set wins over clear
  logic detect_change;
  logic change_read_clear;
  logic change_write_clear;
  assign change_read_clear  = rd_fire && !flag_clear_method
                              && reg_index(s_axi_araddr) == `CWDC_OFF_CHANGE;
  assign change_write_clear = wr_byte && flag_clear_method
                              && aw_off == `CWDC_OFF_CHANGE && wb[3];
  always_ff @(posedge aclk) begin
    if (!aresetn || !global_reset_n) begin
      detect_change <= 1'b0;
    end else if (clk_en) begin
      if (sw_detect || (hw_detect_change && detect_enable)) begin
        detect_change <= 1'b1;
      end else if (change_read_clear || change_write_clear) begin
        detect_change <= 1'b0;
      end
    end
  end
  assign detect_change_irq = detect_change;

  // Ring indicate falls on hardware change with wake enabled, rises when flag or wake enable clears
  always_ff @(posedge aclk) begin
    if (!aresetn || !global_reset_n) begin
      ring_indicate_output <= 1'b1;
    end else if (clk_en) begin
      if (detect_wake_enable && hw_detect_change) begin
        ring_indicate_output <= 1'b0;
      end else if (!detect_change || !detect_wake_enable) begin
        ring_indicate_output <= 1'b1;
      end
    end
  end

  // Sticky events: bit0 detect change, bit1 removal
  // Set wins over a clear so an event in the clearing cycle is kept
  logic [`CWDC_NUM_EVT-1:0] evt_status;
  logic [`CWDC_NUM_EVT-1:0] evt_mask;
  logic [`CWDC_NUM_EVT-1:0] evt_set;
  assign evt_set = {card_removed, sw_detect || hw_detect_change};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_status <= '0;
      evt_mask   <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < `CWDC_NUM_EVT; i++) begin
        if (evt_set[i]) begin
          evt_status[i] <= 1'b1;
        end else if (wr_byte && aw_off == `CWDC_OFF_STATUS && wb[i]) begin
          evt_status[i] <= 1'b0;
        end
      end
      if (wr_byte && aw_off == `CWDC_OFF_MASK) begin
        evt_mask <= wb[`CWDC_NUM_EVT-1:0];
      end
    end
  end
  assign irq = |(evt_status & evt_mask);

  // Read path; unmapped offsets read zero and answer SLVERR
  logic [7:0] rd_byte;
  logic [7:0] rd_off;
  logic [2:0] rd_win;
  always_comb begin
    rd_off  = reg_index(s_axi_araddr);
    rd_win  = win_index(rd_off);
    rd_byte = 8'h00;
    if (rd_win != 3'h7) begin
      rd_byte = win_reg[rd_win];
    end else if (rd_off == `CWDC_OFF_DETECT_CTRL) begin
      rd_byte = {pin_level[1], pin_level[0], 1'b0, detect_wake_enable,
                 2'b00, removal_register_clear, 1'b0};
    end else if (rd_off == `CWDC_OFF_STATUS) begin
      rd_byte = {6'h00, evt_status};
    end else if (rd_off == `CWDC_OFF_MASK) begin
      rd_byte = {6'h00, evt_mask};
    end else if (rd_off == `CWDC_OFF_CONFIG) begin
      rd_byte = {5'h00, pme_enable, flag_clear_method, detect_enable};
    end else if (rd_off == `CWDC_OFF_CHANGE) begin
      rd_byte = {4'h0, detect_change, 3'h0};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (clk_en) begin
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= is_mapped(rd_off) ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // cwdc_regs

// ==== shared/cwdc_params.svh ====
// Register offsets, field positions, reset values for the card window/detect block
`ifndef CWDC_PARAMS_SVH
`define CWDC_PARAMS_SVH
`define CWDC_OFF_WIN0_HIGH   8'h15
`define CWDC_OFF_DETECT_CTRL 8'h16
`define CWDC_OFF_WIN1_HIGH   8'h1D
`define CWDC_OFF_WIN2_HIGH   8'h25
`define CWDC_OFF_WIN3_HIGH   8'h2D
`define CWDC_OFF_WIN4_HIGH   8'h35
`define CWDC_OFF_STATUS      8'h40
`define CWDC_OFF_MASK        8'h44
`define CWDC_OFF_CONFIG      8'h48
`define CWDC_OFF_CHANGE      8'h4C
`define CWDC_WIN_RESET       8'h00
`define CWDC_BIT_WP          7
`define CWDC_BIT_ATTR        6
`define CWDC_BIT_SENSE2      7
`define CWDC_BIT_SENSE1      6
`define CWDC_BIT_SWDETECT    5
`define CWDC_BIT_WAKE        4
`define CWDC_BIT_REMCLR      1
`define CWDC_CTRL_WMASK      8'h12
`define CWDC_CFG_DETECT_EN   0
`define CWDC_CFG_CLEAR_MODE  1
`define CWDC_CFG_PME_EN      2
`define CWDC_NUM_WIN         5
`define CWDC_NUM_EVT         2
`define CWDC_SETTLE_CYCLES   3'h5
`endif

// ==== shared/cwdc_pkg.sv ====
// Types for the card window/detect block
package cwdc_pkg;
  typedef enum logic [2:0] {
    CWDC_W_IDLE = 3'b001,
    CWDC_W_RESP = 3'b010,
    CWDC_W_HOLD = 3'b100
  } cwdc_wstate_t;
  typedef logic [7:0] cwdc_byte_t;
endpackage
